// >>> logic/pmc_consts.vh
// Command codes, field positions, reset values and timing for the command map
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

`define PMC_C_CLEAR   8'h03
`define PMC_C_OCW     8'h4a
`define PMC_C_OTF     8'h4f
`define PMC_C_OTACT   8'h50
`define PMC_C_OTW     8'h51
`define PMC_C_VINOV   8'h55
`define PMC_C_VINACT  8'h56
`define PMC_C_PGON    8'h5e
`define PMC_C_PGOFF   8'h5f
`define PMC_C_TDLY    8'h60
`define PMC_C_TRISE   8'h61
`define PMC_C_SWORD   8'h79
`define PMC_C_SVOUT   8'h7a
`define PMC_C_SIOUT   8'h7b
`define PMC_C_SIN     8'h7c
`define PMC_C_STEMP   8'h7d
`define PMC_C_RVIN    8'h88
`define PMC_C_RVOUT   8'h8b
`define PMC_C_RIOUT   8'h8c
`define PMC_C_RTEMP   8'h8d
`define PMC_C_PREV    8'h98
`define PMC_C_FWVER   8'h9b
`define PMC_C_VOGAIN  8'hd1
`define PMC_C_VOOFS   8'hd2
`define PMC_C_VIGAIN  8'hdd
`define PMC_C_VIOFS   8'hde
`define PMC_C_PINCFG  8'he0
`define PMC_C_GLOGIC  8'he1
`define PMC_C_GPOL    8'he6
`define PMC_C_SERIAL  8'hf0

// Linear words: exponent 0 for amps, degC, volts in, ms; 2^-9 for vout
`define PMC_RST_OCW   16'h0046
`define PMC_RST_OTF   16'h0078
`define PMC_RST_OTW   16'h006e
`define PMC_RST_VINOV 16'h0055
`define PMC_RST_PGON  16'h0866
`define PMC_RST_PGOFF 16'h0700
`define PMC_RST_TDLY  16'h0028
`define PMC_RST_TRISE 16'h0014
`define PMC_RST_TRIM  16'h0000
`define PMC_RST_OTACT 8'hb8
`define PMC_RST_VINACT 8'hc0
`define PMC_RST_PREV  8'h22
`define PMC_RST_PINCFG 8'h01
`define PMC_RST_GLOGIC 8'h01
`define PMC_RST_GPOL  8'h01
`define PMC_SN_BYTES  12

`define PMC_SW_PG     11
`define PMC_SW_OFF    6
`define PMC_SW_TEMP   2
`define PMC_SW_CML    1
`define PMC_SIOUT_OCW 5
`define PMC_SIN_OVF   7
`define PMC_STEMP_OTF 7
`define PMC_STEMP_OTW 6
`define PMC_CFG_AND   1
`define PMC_CFG_SENSE 0
`define PMC_POL_BIT   0

`define PMC_CLK_HZ    20000000
`define PMC_TICK_MS   1

`endif

// >>> logic/pmc_command_map.v
// Command register bank and serial management slave of a power converter module
`timescale 1ns/1ns
`include "pmc_consts.vh"

module pmc_command_map #(
	parameter        MS_CYC   = `PMC_CLK_HZ / 1000 * `PMC_TICK_MS,
	parameter [6:0]  DEV_ADDR = 7'h40,
	parameter [7:0]  FW_VER   = 8'h10   // Arbitrary value
)(
	input  wire        mclk,
	input  wire        rst_n,
	input  wire        scl_i,
	input  wire        sda_i,
	output reg         sda_o,
	output reg         sda_oe,
	input  wire        prim_en_i,
	input  wire        secondary_onoff_pin,
	input  wire [15:0] vin_meas,
	input  wire [15:0] vout_meas,
	input  wire [15:0] iout_meas,
	input  wire [15:0] temp_meas,
	output reg         conv_en,
	output reg         ramp_active,
	output reg         output_in_regulation_flag
);

localparam [3:0] S_IDLE = 4'h1;
localparam [3:0] S_DLY  = 4'h2;
localparam [3:0] S_RISE = 4'h4;
localparam [3:0] S_ON   = 4'h8;

function [3:0] idx16;
	input [7:0] c;
	begin
		case (c)
		`PMC_C_OCW:    idx16 = 4'h0;
		`PMC_C_OTF:    idx16 = 4'h1;
		`PMC_C_OTW:    idx16 = 4'h2;
		`PMC_C_VINOV:  idx16 = 4'h3;
		`PMC_C_PGON:   idx16 = 4'h4;
		`PMC_C_PGOFF:  idx16 = 4'h5;
		`PMC_C_TDLY:   idx16 = 4'h6;
		`PMC_C_TRISE:  idx16 = 4'h7;
		`PMC_C_VOGAIN: idx16 = 4'h8;
		`PMC_C_VOOFS:  idx16 = 4'h9;
		`PMC_C_VIGAIN: idx16 = 4'ha;
		`PMC_C_VIOFS:  idx16 = 4'hb;
		default:       idx16 = 4'hf;
		endcase
	end
endfunction

function [15:0] dflt16;
	input [3:0] i;
	begin
		case (i)
		4'h0:    dflt16 = `PMC_RST_OCW;
		4'h1:    dflt16 = `PMC_RST_OTF;
		4'h2:    dflt16 = `PMC_RST_OTW;
		4'h3:    dflt16 = `PMC_RST_VINOV;
		4'h4:    dflt16 = `PMC_RST_PGON;
		4'h5:    dflt16 = `PMC_RST_PGOFF;
		4'h6:    dflt16 = `PMC_RST_TDLY;
		4'h7:    dflt16 = `PMC_RST_TRISE;
		default: dflt16 = `PMC_RST_TRIM;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin sampling: three flops, a change counts when stages two and three agree
reg  [3:0]  sy1_q, sy2_q, sy3_q, flt_q, prv_q;
wire [3:0]  dis = sy2_q ^ sy3_q;

always @(posedge mclk) begin
	if (!rst_n) begin
		sy1_q <= 4'hf;
		sy2_q <= 4'hf;
		sy3_q <= 4'hf;
		flt_q <= 4'hf;
		prv_q <= 4'hf;
	end else begin
		sy1_q <= {secondary_onoff_pin, prim_en_i, sda_i, scl_i};
		sy2_q <= sy1_q;
		sy3_q <= sy2_q;
		flt_q <= (sy3_q & ~dis) | (flt_q & dis);
		prv_q <= flt_q;
	end
end

wire scl_f  = flt_q[0];
wire sda_f  = flt_q[1];
wire scl_r  = scl_f & ~prv_q[0];
wire scl_fl = ~scl_f & prv_q[0];
wire start  = scl_f & prv_q[0] & prv_q[1] & ~sda_f;
wire stop   = scl_f & prv_q[0] & ~prv_q[1] & sda_f;

////////////////////////////////////////////////////////////////////////////////
// Register storage
reg  [15:0] rw16_q [0:11];
reg  [7:0]  sn_q [0:`PMC_SN_BYTES-1];
reg  [7:0]  fw_q, pincfg_q, glogic_q, gpol_q;
reg  [7:0]  siout_q, sin_q, stemp_q;
reg         cml_q, pg_q;
reg  [3:0]  st_q;
// Serial engine state
reg  [3:0]  bitc_q;
reg  [4:0]  byten_q;
reg         act_q, rd_q, hnak_q;
reg  [7:0]  sh_q, tx_q, cmd_q;
reg  [15:0] wbuf_q;

wire [4:0]  nbyt   = byten_q - 5'd2;
wire        wr_end = stop & act_q & ~rd_q & (byten_q >= 5'd2);
wire [3:0]  cidx   = idx16(cmd_q);
wire        is8rw  = (cmd_q == `PMC_C_FWVER) | (cmd_q == `PMC_C_PINCFG) |
                     (cmd_q == `PMC_C_GLOGIC) | (cmd_q == `PMC_C_GPOL);
wire        clr    = wr_end & (cmd_q == `PMC_C_CLEAR) & (nbyt == 5'd0);
wire        wr16   = wr_end & (cidx != 4'hf) & (nbyt == 5'd2);
wire        wr8    = wr_end & is8rw & (nbyt == 5'd1);
wire        refuse = wr_end & (nbyt != 5'd0) & ~wr16 & ~wr8 &
                     (cmd_q != `PMC_C_SERIAL);

////////////////////////////////////////////////////////////////////////////////
// Threshold checks against same-domain telemetry
wire oc_w   = iout_meas > rw16_q[0];
wire ot_f   = temp_meas > rw16_q[1];
wire ot_w   = temp_meas > rw16_q[2];
wire vin_f  = vin_meas > rw16_q[3];
wire fault  = stemp_q[`PMC_STEMP_OTF] | sin_q[`PMC_SIN_OVF];

integer i;
integer j;
always @(posedge mclk) begin
	if (!rst_n) begin
		for (i = 0; i < 12; i = i + 1)
			rw16_q[i] <= dflt16(i[3:0]);
		fw_q     <= FW_VER;
		pincfg_q <= `PMC_RST_PINCFG;
		glogic_q <= `PMC_RST_GLOGIC;
		gpol_q   <= `PMC_RST_GPOL;
	end else begin
		// Read-only and unlisted codes never reach the stores
		if (wr16)
			rw16_q[cidx] <= wbuf_q;
		if (wr8 && cmd_q == `PMC_C_FWVER)
			fw_q <= wbuf_q[7:0];
		if (wr8 && cmd_q == `PMC_C_PINCFG)
			pincfg_q <= wbuf_q[7:0];
		if (wr8 && cmd_q == `PMC_C_GLOGIC)
			glogic_q <= wbuf_q[7:0];
		if (wr8 && cmd_q == `PMC_C_GPOL)
			gpol_q <= wbuf_q[7:0];
	end
end

// Latched status: a new event in the clear cycle wins over the clear
always @(posedge mclk) begin
	if (!rst_n) begin
		siout_q <= 8'h00;
		sin_q   <= 8'h00;
		stemp_q <= 8'h00;
		cml_q   <= 1'b0;
		pg_q    <= 1'b0;
	end else begin
		siout_q[`PMC_SIOUT_OCW] <= oc_w | (siout_q[`PMC_SIOUT_OCW] & ~clr);
		sin_q[`PMC_SIN_OVF]     <= vin_f | (sin_q[`PMC_SIN_OVF] & ~clr);
		stemp_q[`PMC_STEMP_OTF] <= ot_f | (stemp_q[`PMC_STEMP_OTF] & ~clr);
		stemp_q[`PMC_STEMP_OTW] <= ot_w | (stemp_q[`PMC_STEMP_OTW] & ~clr);
		cml_q <= refuse | (cml_q & ~clr);
		if (vout_meas >= rw16_q[4])
			pg_q <= 1'b1;
		else if (vout_meas <= rw16_q[5])
			pg_q <= 1'b0;
	end
end

wire any_st = |siout_q | |sin_q | |stemp_q | cml_q;
wire [15:0] sword;

assign sword[15:12]         = {1'b0, |siout_q, |sin_q, 1'b0};
assign sword[`PMC_SW_PG]    = pg_q;
assign sword[10:7]          = 4'h0;
assign sword[`PMC_SW_OFF]   = ~conv_en;
assign sword[5:3]           = 3'b000;
assign sword[`PMC_SW_TEMP]  = |stemp_q;
assign sword[`PMC_SW_CML]   = cml_q;
assign sword[0]             = ~any_st & conv_en;

////////////////////////////////////////////////////////////////////////////////
// Read mux
reg  [15:0] rd16;
always @* begin
	rd16 = 16'h0000;
	if (cidx != 4'hf)
		rd16 = rw16_q[cidx];
	else begin
		case (cmd_q)
		`PMC_C_OTACT:  rd16 = {8'h00, `PMC_RST_OTACT};
		`PMC_C_VINACT: rd16 = {8'h00, `PMC_RST_VINACT};
		`PMC_C_SWORD:  rd16 = sword;
		`PMC_C_SVOUT:  rd16 = 16'h0000;
		`PMC_C_SIOUT:  rd16 = {8'h00, siout_q};
		`PMC_C_SIN:    rd16 = {8'h00, sin_q};
		`PMC_C_STEMP:  rd16 = {8'h00, stemp_q};
		`PMC_C_RVIN:   rd16 = vin_meas;
		`PMC_C_RVOUT:  rd16 = vout_meas;
		`PMC_C_RIOUT:  rd16 = iout_meas;
		`PMC_C_RTEMP:  rd16 = temp_meas;
		`PMC_C_PREV:   rd16 = {8'h00, `PMC_RST_PREV};
		`PMC_C_FWVER:  rd16 = {8'h00, fw_q};
		`PMC_C_PINCFG: rd16 = {8'h00, pincfg_q};
		`PMC_C_GLOGIC: rd16 = {8'h00, glogic_q};
		`PMC_C_GPOL:   rd16 = {8'h00, gpol_q};
		default:       rd16 = 16'hffff;
		endcase
	end
end

wire [4:0] didx = byten_q - 5'd1;
wire [7:0] rdb  = (cmd_q == `PMC_C_SERIAL) ?
                  ((didx < `PMC_SN_BYTES) ? sn_q[didx[3:0]] : 8'hff) :
                  (didx == 5'd0) ? rd16[7:0] :
                  (didx == 5'd1) ? rd16[15:8] : 8'hff;

////////////////////////////////////////////////////////////////////////////////
// Serial slave: no clock stretching, so replies depend only on sampled edges

always @(posedge mclk) begin
	if (!rst_n) begin
		bitc_q  <= 4'h0;
		byten_q <= 5'h00;
		act_q   <= 1'b0;
		rd_q    <= 1'b0;
		hnak_q  <= 1'b0;
		sh_q    <= 8'h00;
		tx_q    <= 8'h00;
		cmd_q   <= 8'h00;
		wbuf_q  <= 16'h0000;
		sda_o   <= 1'b0;
		sda_oe  <= 1'b0;
	end else if (start) begin
		// First fall after a start wraps the count to bit 0; stale read mode must not drive
		act_q   <= 1'b1;
		rd_q    <= 1'b0;
		bitc_q  <= 4'hf;
		byten_q <= 5'h00;
		hnak_q  <= 1'b0;
		sda_oe  <= 1'b0;
	end else if (stop) begin
		act_q  <= 1'b0;
		sda_oe <= 1'b0;
	end else if (act_q) begin
		if (scl_r) begin
			if (bitc_q == 4'h8)
				hnak_q <= sda_f;
			else
				sh_q <= {sh_q[6:0], sda_f};
		end
		if (scl_fl) begin
			if (bitc_q == 4'h7) begin
				bitc_q <= 4'h8;
				if (byten_q != 5'h1f)
					byten_q <= byten_q + 5'd1;
				if (byten_q == 5'h00) begin
					if (sh_q[7:1] == DEV_ADDR) begin
						sda_oe <= 1'b1;
						rd_q   <= sh_q[0];
					end else
						act_q <= 1'b0;
				end else if (!rd_q) begin
					sda_oe <= 1'b1;
					if (byten_q == 5'd1)
						cmd_q <= sh_q;
					else if (byten_q == 5'd2)
						wbuf_q[7:0] <= sh_q;
					else if (byten_q == 5'd3)
						wbuf_q[15:8] <= sh_q;
				end else
					sda_oe <= 1'b0;
			end else if (bitc_q == 4'h8) begin
				bitc_q <= 4'h0;
				if (rd_q && !hnak_q) begin
					tx_q   <= {rdb[6:0], 1'b0};
					sda_oe <= ~rdb[7];
				end else begin
					sda_oe <= 1'b0;
					if (rd_q)
						act_q <= 1'b0;
				end
			end else begin
				bitc_q <= bitc_q + 4'h1;
				if (rd_q) begin
					sda_oe <= ~tx_q[7];
					tx_q   <= {tx_q[6:0], 1'b0};
				end
			end
		end
	end
end

// Serial block is written byte by byte as it arrives
always @(posedge mclk) begin
	if (!rst_n) begin
		for (j = 0; j < `PMC_SN_BYTES; j = j + 1)
			sn_q[j] <= 8'h00;
	end else if (act_q && !rd_q && scl_fl && bitc_q == 4'h7 && cmd_q == `PMC_C_SERIAL &&
	             byten_q >= 5'd2 && nbyt < `PMC_SN_BYTES) begin
		sn_q[nbyt[3:0]] <= sh_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Turn-on sequencing in millisecond steps
reg  [14:0] tick_q;
reg  [15:0] ms_q;
wire        tick  = (tick_q == MS_CYC - 1);
wire        sec_ok = ~pincfg_q[`PMC_CFG_AND] |
                     (flt_q[3] == pincfg_q[`PMC_CFG_SENSE]);
wire        en_ok = flt_q[2] & sec_ok & ~fault;

always @(posedge mclk) begin
	if (!rst_n) begin
		tick_q      <= 15'h0000;
		ms_q        <= 16'h0000;
		st_q        <= S_IDLE;
		conv_en     <= 1'b0;
		ramp_active <= 1'b0;
		output_in_regulation_flag <= 1'b0;
	end else begin
		tick_q <= tick ? 15'h0000 : tick_q + 15'h0001;
		// Polarity 0 pulls the pin low while good
		output_in_regulation_flag <= gpol_q[`PMC_POL_BIT] ? pg_q : ~pg_q;
		if (!en_ok) begin
			st_q        <= S_IDLE;
			conv_en     <= 1'b0;
			ramp_active <= 1'b0;
		end else begin
			case (st_q)
			S_IDLE: begin
				st_q <= S_DLY;
				ms_q <= 16'h0000;
			end
			S_DLY: begin
				if (ms_q >= rw16_q[6]) begin
					st_q        <= S_RISE;
					ms_q        <= 16'h0000;
					conv_en     <= 1'b1;
					ramp_active <= 1'b1;
				end else if (tick)
					ms_q <= ms_q + 16'h0001;
			end
			S_RISE: begin
				if (ms_q >= rw16_q[7]) begin
					st_q        <= S_ON;
					ramp_active <= 1'b0;
				end else if (tick)
					ms_q <= ms_q + 16'h0001;
			end
			S_ON: st_q <= S_ON;
			default: st_q <= S_IDLE;
			endcase
		end
	end
end

endmodule

// >>> bench/pmc_command_map_props.sv
// Concurrent checks on the command map pins
`timescale 1ns/1ns
module pmc_command_map_props #(
	parameter MS_CYC = 20000
)(
	input wire        mclk,
	input wire        rst_n,
	input wire        scl_i,
	input wire        sda_i,
	input wire        sda_o,
	input wire        sda_oe,
	input wire        prim_en_i,
	input wire        secondary_onoff_pin,
	input wire [15:0] vin_meas,
	input wire [15:0] vout_meas,
	input wire [15:0] iout_meas,
	input wire [15:0] temp_meas,
	input wire        conv_en,
	input wire        ramp_active,
	input wire        output_in_regulation_flag
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	int          en_cnt;
	int          ramp_cnt;
	int          quiet_cnt;
	logic [15:0] vout_prev;
	// Our count starts before the enable filter does, so it only bounds from below
	always @(posedge mclk) begin
		en_cnt <= (!rst_n || !prim_en_i || conv_en) ? 0 : en_cnt + 1;
		ramp_cnt <= (!rst_n || !ramp_active) ? 0 : ramp_cnt + 1;
		vout_prev <= vout_meas;
		if (!rst_n || !scl_i || !sda_i || vout_meas != vout_prev)
			quiet_cnt <= 0;
		else if (quiet_cnt < 100)
			quiet_cnt <= quiet_cnt + 1;
	end
	sequence s_ramp_end;
		ramp_active ##1 (!ramp_active && conv_en);
	endsequence
	// Bus idle long enough that any committed polarity write has landed
	sequence s_mid_idle;
		quiet_cnt >= 12 && vout_meas > 16'h0700 && vout_meas < 16'h0866;
	endsequence
	a_ramp_in_conv: assert property (ramp_active |-> conv_en)
		else $error("ramp without enable");
	a_ramp_start: assert property ($rose(conv_en) |-> ramp_active)
		else $error("enable without ramp");
	a_delay_min: assert property ($rose(conv_en) |-> en_cnt >= 39 * MS_CYC)
		else $error("turn on delay too short");
	a_ramp_len: assert property (s_ramp_end |-> ramp_cnt >= 19 * MS_CYC - 2
		&& ramp_cnt <= 20 * MS_CYC + 2) else $error("ramp length wrong");
	a_en_drop: assert property ($fell(prim_en_i) |-> ##[1:6] !conv_en && !ramp_active)
		else $error("enable drop ignored");
	a_fault_stop: assert property (vin_meas > 16'h0055 || temp_meas > 16'h0078
		|-> ##[1:3] !conv_en) else $error("fault did not stop");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("data moved with clock high");
	a_good_hold: assert property (s_mid_idle |-> $stable(output_in_regulation_flag))
		else $error("good pin moved inside band");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !conv_en && !sda_oe)
		else $error("outputs active in reset");
endmodule
bind pmc_command_map pmc_command_map_props #(.MS_CYC(MS_CYC)) u_props (
	.mclk(mclk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .prim_en_i(prim_en_i), .secondary_onoff_pin(secondary_onoff_pin),
	.vin_meas(vin_meas), .vout_meas(vout_meas), .iout_meas(iout_meas),
	.temp_meas(temp_meas), .conv_en(conv_en), .ramp_active(ramp_active),
	.output_in_regulation_flag(output_in_regulation_flag));

// >>> bench/pmc_host_model.sv
// Bus host model: drives the serial clock and pulls the data line low
`timescale 1ns/1ns
module pmc_host_model (
	output logic scl,
	output logic sda_pull,
	input  wire  sda
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// Each clock phase is 400 ns so the slave filter always agrees; data moves mid-low
	task automatic put_bit(input logic b);
		scl = 1'b0;
		#200 sda_pull = ~b;
		#200 scl = 1'b1;
		#400;
	endtask
	task automatic get_bit(output logic b);
		scl = 1'b0;
		#200 sda_pull = 1'b0;
		#200 scl = 1'b1;
		#200 b = sda;
		#200;
	endtask
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int k = 7; k >= 0; k--) put_bit(d[k]);
		get_bit(b);
		ack = ~b;
	endtask
	// The last byte read is refused so the slave lets go of the line
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic b;
		for (int k = 7; k >= 0; k--) begin
			get_bit(b);
			d[k] = b;
		end
		put_bit(last);
	endtask
	task automatic xfer(input logic [6:0] adr, input logic [7:0] cmd, input int nw,
		input logic [15:0] wd, input int nr, output logic [15:0] rd, output logic ack);
		logic       x;
		logic [7:0] d;
		rd = 16'h0000;
		sda_pull = 1'b1;
		#400 put_byte({adr, 1'b0}, ack);
		put_byte(cmd, x);
		for (int k = 0; k < nw; k++) put_byte(wd[8*k +: 8], x);
		if (nr > 0) begin
			put_bit(1'b1);
			sda_pull = 1'b1;
			#400 put_byte({adr, 1'b1}, x);
			for (int k = 0; k < nr; k++) begin
				get_byte(k == nr - 1, d);
				rd[8*k +: 8] = d;
			end
		end
		put_bit(1'b0);
		sda_pull = 1'b0;
		#400;
	endtask
endmodule

// >>> bench/pmc_command_map_tb.sv
// Testbench of the command map: table, refusals, status bits and sequencing
`timescale 1ns/1ns
module pmc_command_map_tb;
	localparam int MS = 20;
	typedef struct {
		logic [7:0]  cmd;
		int          n;
		logic [15:0] exp;
	} pmc_row_t;
	logic        mclk;
	logic        rst_n;
	logic        prim_en_i;
	logic        sec_pin;
	logic [15:0] vin_meas;
	logic [15:0] vout_meas;
	logic [15:0] iout_meas;
	logic [15:0] temp_meas;
	wire         scl;
	wire         sda_pull;
	wire         sda_o;
	wire         sda_oe;
	wire         conv_en;
	wire         ramp_active;
	wire         pg_pin;
	int          fails;
	int          samples_checked;
	int          cyc;
	int          n;
	logic [15:0] v;
	logic        a;
	pmc_row_t    rows [28];
	// Pull-up on the shared data line
	wire sda = (sda_pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
	pmc_command_map #(.MS_CYC(MS)) uut (
		.mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .prim_en_i(prim_en_i), .secondary_onoff_pin(sec_pin),
		.vin_meas(vin_meas), .vout_meas(vout_meas), .iout_meas(iout_meas),
		.temp_meas(temp_meas), .conv_en(conv_en), .ramp_active(ramp_active),
		.output_in_regulation_flag(pg_pin));
	pmc_host_model host (.scl(scl), .sda_pull(sda_pull), .sda(sda));
	always #25 mclk = ~mclk;
	task automatic check(input string w, input logic [15:0] seen, input logic [15:0] e);
		samples_checked++;
		if (seen !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", w, e, seen);
		end
	endtask
	task automatic wr(input logic [7:0] c, input int nb, input logic [15:0] d);
		logic [15:0] r;
		logic        x;
		@(negedge mclk);
		host.xfer(7'h40, c, nb, d, 0, r, x);
	endtask
	task automatic rchk(input string w, input logic [7:0] c, input int nb,
		input logic [15:0] e);
		logic [15:0] r;
		logic        x;
		@(negedge mclk);
		host.xfer(7'h40, c, 0, 16'h0000, nb, r, x);
		check($sformatf("%s %h", w, c), r, e);
	endtask
	task automatic wait_sig(input int s, input logic val, output int cnt);
		cnt = 0;
		while ((s == 0 ? conv_en : ramp_active) !== val && cnt < 3000) begin
			@(negedge mclk);
			cnt++;
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Ceiling sits well above the expected run of about 40000 cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			fails++;
			test_done;
		end
	end
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		prim_en_i = 1'b0;
		sec_pin = 1'b1;
		vin_meas = 16'h0030;
		vout_meas = 16'h0100;
		iout_meas = 16'h0010;
		temp_meas = 16'h0019;
		fails = 0;
		samples_checked = 0;
		rows = '{'{8'h4a, 2, 16'h0046}, '{8'h4f, 2, 16'h0078}, '{8'h51, 2, 16'h006e},
			'{8'h55, 2, 16'h0055}, '{8'h50, 1, 16'h00b8}, '{8'h56, 1, 16'h00c0},
			'{8'h5e, 2, 16'h0866}, '{8'h5f, 2, 16'h0700}, '{8'h60, 2, 16'h0028},
			'{8'h61, 2, 16'h0014}, '{8'h79, 2, 16'h0040}, '{8'h7a, 1, 16'h0000},
			'{8'h7b, 1, 16'h0000}, '{8'h7c, 1, 16'h0000}, '{8'h7d, 1, 16'h0000},
			'{8'h88, 2, 16'h0030}, '{8'h8b, 2, 16'h0100}, '{8'h8c, 2, 16'h0010},
			'{8'h98, 1, 16'h0022}, '{8'h9b, 1, 16'h0010}, '{8'hd1, 2, 16'h0000},
			'{8'hdd, 2, 16'h0000}, '{8'he0, 1, 16'h0001}, '{8'he6, 1, 16'h0001},
			'{8'hd2, 2, 16'h0000}, '{8'hde, 2, 16'h0000}, '{8'he1, 1, 16'h0001},
			'{8'h8d, 2, 16'h0019}};
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		repeat (10) @(negedge mclk);
		check("pg pin", pg_pin, 1'b0);
		foreach (rows[k]) rchk("reset", rows[k].cmd, rows[k].n, rows[k].exp);
		wr(8'h50, 1, 16'h0055);
		rchk("ro", 8'h50, 1, 16'h00b8);
		wr(8'h4a, 1, 16'h0033);
		rchk("short", 8'h4a, 2, 16'h0046);
		wr(8'h03, 0, 16'h0000);
		wr(8'h77, 1, 16'h0012);
		rchk("cml", 8'h79, 2, 16'h0042);
		@(negedge mclk);
		host.xfer(7'h42, 8'h79, 0, 16'h0000, 2, v, a);
		check("foreign ack", a, 1'b0);
		wr(8'h03, 0, 16'h0000);
		rchk("clear", 8'h79, 2, 16'h0040);
		wr(8'h4a, 2, 16'h0020);
		rchk("oc lim", 8'h4a, 2, 16'h0020);
		wr(8'hdd, 2, 16'h1234);
		rchk("trim", 8'hdd, 2, 16'h1234);
		wr(8'hf0, 2, 16'hbeef);
		rchk("serial", 8'hf0, 2, 16'hbeef);
		iout_meas = 16'h0021;
		rchk("oc warn", 8'h7b, 1, 16'h0020);
		iout_meas = 16'h0020;
		wr(8'h03, 0, 16'h0000);
		rchk("oc equal", 8'h7b, 1, 16'h0000);
		temp_meas = 16'h006f;
		rchk("ot warn", 8'h7d, 1, 16'h0040);
		rchk("ot sum", 8'h79, 2, 16'h0044);
		temp_meas = 16'h0019;
		wr(8'h03, 0, 16'h0000);
		vout_meas = 16'h0866;
		repeat (8) @(negedge mclk);
		check("pg on", pg_pin, 1'b1);
		rchk("pg bit", 8'h79, 2, 16'h0840);
		vout_meas = 16'h0701;
		repeat (16) @(negedge mclk);
		check("pg hold", pg_pin, 1'b1);
		vout_meas = 16'h0700;
		repeat (8) @(negedge mclk);
		check("pg off", pg_pin, 1'b0);
		wr(8'he6, 1, 16'h0000);
		repeat (8) @(negedge mclk);
		check("pg neg", pg_pin, 1'b1);
		vout_meas = 16'h0100;
		wr(8'he6, 1, 16'h0001);
		prim_en_i = 1'b1;
		wait_sig(0, 1'b1, n);
		check("delay", n >= 39 * MS && n <= 41 * MS, 1'b1);
		wait_sig(1, 1'b0, n);
		check("rise", n >= 19 * MS && n <= 21 * MS && conv_en, 1'b1);
		rchk("on sum", 8'h79, 2, 16'h0001);
		wr(8'he0, 1, 16'h0002);
		repeat (6) @(negedge mclk);
		check("and off", conv_en, 1'b0);
		sec_pin = 1'b0;
		wait_sig(0, 1'b1, n);
		check("and on", n >= 39 * MS && n <= 41 * MS, 1'b1);
		vin_meas = 16'h0056;
		repeat (4) @(negedge mclk);
		vin_meas = 16'h0030;
		rchk("vin ov", 8'h7c, 1, 16'h0080);
		check("latched", conv_en, 1'b0);
		wr(8'h03, 0, 16'h0000);
		wait_sig(0, 1'b1, n);
		check("restart", n <= 41 * MS, 1'b1);
		prim_en_i = 1'b0;
		repeat (8) @(negedge mclk);
		check("drop", conv_en || ramp_active, 1'b0);
		test_done;
	end
endmodule
